// ==== design/sov_consts.svh ====
// constants of the spindle overload supervisor and parameter-mode logic
// assumes one 250 MHz core clock and a power-on style asynchronous reset
`ifndef SOV_CONSTS_SVH
`define SOV_CONSTS_SVH

// timebase
`define SOV_CLK_PERIOD_NS 4
`define SOV_MS_NS 1000000
`define SOV_MS_PER_S 1000

// overload levels and allowed times
`define SOV_OVL_MIN_LEDS 3'h4
`define SOV_LVL5_LEDS 3'h5
`define SOV_LVL6_LEDS 3'h6
`define SOV_LIM4_S 30
`define SOV_LIM5_S 10
`define SOV_LIM6_S 5

// power-up hold, buzzer, blink and pattern timing
`define SOV_HOLD_S 3
`define SOV_BEEP_MS 100
`define SOV_BEEP_COUNT 3
`define SOV_BLINK_MS 250
`define SOV_PAT_BIT_MS 10
`define SOV_PAT_LAST_BIT 4'h9

// speed cap with air check overridden, rpm
`define SOV_AIR_CAP_RPM 16'h7530

// display codes
`define SOV_CODE_NONE 8'h00
`define SOV_CODE_A3 8'hA3
`define SOV_CODE_E8 8'hE8
`define SOV_CODE_DMG 8'hEF

// register byte addresses
`define SOV_A_CFG 8'h00
`define SOV_A_FIX1 8'h04
`define SOV_A_FIX2 8'h08
`define SOV_A_MAX1 8'h0C
`define SOV_A_MAX2 8'h10
`define SOV_A_STAT 8'h14

// configuration fields
`define SOV_CFG_ERR_INV 0
`define SOV_CFG_PAT 1
`define SOV_CFG_PANEL_ADJ 2
`define SOV_CFG_DIR_EN 3
`define SOV_CFG_AIR_OVR 4
`define SOV_CFG_RUN_POL 5
`define SOV_CFG_SRC_LO 6
`define SOV_CFG_SRC_HI 7
`define SOV_LIM_EN 16
`define SOV_CFG_RESET 8'h00
`define SOV_LIM_RESET 17'h00000

`endif

// ==== design/sov_pkg.sv ====
// types of the spindle overload supervisor and parameter-mode logic
// assumes sov_consts.svh for all numeric constants except the state and source encodings
package sov_pkg;
	typedef logic [2:0] sov_lvl_t;
	typedef logic [15:0] sov_speed_t;
	typedef logic [7:0] sov_code_t;

	// power-up sequence, gray along check-hold-beep-wait-param
	typedef enum logic [2:0] {
		PU_CHECK = 3'h0,
		PU_HOLD = 3'h1,
		PU_BEEP = 3'h3,
		PU_WAIT_REL = 3'h2,
		PU_PARAM = 3'h6,
		PU_NORMAL = 3'h4
	} sov_pu_e;

	typedef enum logic [1:0] {
		SRC_ANALOG = 2'h0,
		SRC_PULSE = 2'h1,
		SRC_POINT = 2'h2
	} sov_src_e;
endpackage

// ==== design/sov_top.sv ====
// spindle overload supervisor, error handling and power-up parameter mode
// assumes synchronous inputs, register port writes only take in parameter mode
//
// Summary of operation
// R1 - four or more lit load segments is overload; warning indicator blinks meanwhile.
// R2 - overload shows warning code A3 on the speed display.
// R3 - overload drives the external warning output active.
// R4 - four segments may last at most thirty seconds before fault.
// R5 - five segments may last at most ten seconds before fault.
// R6 - six segments may last at most five seconds before fault.
// R7 - on timeout the motor stops and the error indicator lights.
// R8 - overload fault shows E8 and drives the error output active.
// R9 - setting, off by default, inverts the error output line.
// R10 - internal damage fault latches forever, ignoring every release request.
// R11 - parameter mode refuses every motor start and stop command.
// R12 - parameter mode is left only by a power cycle.
// R13 - parameter mode needs reset button held at power-on for three seconds.
// R14 - after the hold, beep three times; parameter mode starts on release.
// R15 - option, off by default, sends active code as patterned output signal.
// R16 - setting, off by default, allows panel speed adjust in automatic mode.
// R17 - per motor, optional fixed and maximum speed, both disabled by default.
// R18 - air check override allows start without air, caps speed 30000 rpm.
// R19 - automatic speed from analog, pulse count or speed point inputs.
// R20 - with direction option on, direction input with start means reverse.
// R21 - run output active while rotating by default, or while stopped.
// R22 - automatic mode clears error on release input off, on, off.
// R23 - load below four segments restarts overload timing and clears warning.
`include "sov_consts.svh"

module sov_top #(
	parameter int unsigned TICK_CYCLES = `SOV_MS_NS / `SOV_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// panel and machine inputs
	input wire sov_pkg::sov_lvl_t LOAD_LEDS,
	input wire logic PANEL_RESET_BTN,
	input wire logic PANEL_START,
	input wire logic AUTO_MODE,
	input wire logic START_CMD,
	input wire logic DIR_IN,
	input wire logic ERR_RELEASE,
	input wire logic INT_DAMAGE,
	input wire logic AIR_OK,
	input wire logic MOTOR_TURNING,
	input wire logic MOTOR_SEL,
	// speed sources
	input wire sov_pkg::sov_speed_t ANALOG_SPEED,
	input wire sov_pkg::sov_speed_t PULSE_SPEED,
	input wire sov_pkg::sov_speed_t POINT_SPEED,
	input wire sov_pkg::sov_speed_t PANEL_SPEED,
	// motor drive
	output logic MOTOR_EN,
	output logic MOTOR_REV,
	output sov_pkg::sov_speed_t SPEED_CMD,
	// indicators and external outputs
	output logic WARN_LED,
	output logic ERR_LED,
	output sov_pkg::sov_code_t DISP_CODE,
	output logic WARN_OUT,
	output logic ERR_OUT,
	output logic RUN_OUT,
	output logic BUZZER,
	output logic PARAM_MODE
);
	import sov_pkg::*;

	localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
	localparam logic [15:0] HOLD_MS = 16'(`SOV_HOLD_S * `SOV_MS_PER_S);
	localparam logic [15:0] LIM4_MS = 16'(`SOV_LIM4_S * `SOV_MS_PER_S);
	localparam logic [15:0] LIM5_MS = 16'(`SOV_LIM5_S * `SOV_MS_PER_S);
	localparam logic [15:0] LIM6_MS = 16'(`SOV_LIM6_S * `SOV_MS_PER_S);
	localparam logic [15:0] BEEP_MS = 16'(`SOV_BEEP_MS);
	localparam logic [15:0] BLINK_MS = 16'(`SOV_BLINK_MS);
	localparam logic [15:0] PAT_MS = 16'(`SOV_PAT_BIT_MS);
	localparam logic [2:0] BEEP_LAST = 3'(2 * `SOV_BEEP_COUNT - 1);

	logic [17:0] tick_cnt_ff;
	logic tick_ff;
	sov_pu_e pu_ff, nxt_pu;
	logic [15:0] pu_ms_ff;
	logic [2:0] beep_ph_ff;
	logic phase_done;
	logic [7:0] cfg_ff;
	logic [16:0] fix_ff [2];
	logic [16:0] max_ff [2];
	sov_lvl_t lvl_ff;
	logic ovl_ff;
	logic [15:0] ovl_ms_ff;
	logic [15:0] lim_ms;
	logic timeout;
	logic ovl_err_ff, dmg_ff, err_any;
	logic rel_prev_ff, rel_arm_ff, btn_prev_ff, release_req;
	logic [15:0] blink_ms_ff;
	logic blink_ff;
	logic [15:0] pat_ms_ff;
	logic [3:0] pat_idx_ff;
	sov_code_t cur_code;
	logic [9:0] pat_frame;
	logic pat_bit, wr_ok, start_req;
	sov_speed_t src_speed, lim_speed;
	logic [16:0] sel_fix, sel_max;
	logic motor_en_ff, motor_rev_ff, warn_led_ff, err_led_ff, warn_out_ff;
	logic err_out_ff, run_out_ff, buzzer_ff;
	sov_speed_t speed_ff;
	sov_code_t disp_ff;
	logic [31:0] rdata_ff;
	logic param_ff;

	// millisecond timebase
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tick_cnt_ff <= 18'h00000;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (tick_cnt_ff == TICK_LAST);
			tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? 18'h00000 : tick_cnt_ff + 18'h00001;
		end
	end

	// power-up sequence
	assign phase_done = (pu_ff == PU_BEEP) && tick_ff && (pu_ms_ff == BEEP_MS - 16'h0001);

	always_comb begin
		nxt_pu = pu_ff;
		case (pu_ff)
			// R13 held at power-on
			PU_CHECK: nxt_pu = PANEL_RESET_BTN ? PU_HOLD : PU_NORMAL;
			// R13 three second hold
			PU_HOLD: begin
				if (!PANEL_RESET_BTN)
					nxt_pu = PU_NORMAL;
				else if (tick_ff && pu_ms_ff >= HOLD_MS - 16'h0001)
					nxt_pu = PU_BEEP;
			end
			// R14 three beeps
			PU_BEEP: begin
				if (phase_done && beep_ph_ff == BEEP_LAST)
					nxt_pu = PU_WAIT_REL;
			end
			// R14 begin on release
			PU_WAIT_REL: begin
				if (!PANEL_RESET_BTN)
					nxt_pu = PU_PARAM;
			end
			// R12 only power cycle leaves
			PU_PARAM: nxt_pu = PU_PARAM;
			PU_NORMAL: nxt_pu = PU_NORMAL;
			default: nxt_pu = PU_CHECK;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pu_ff <= PU_CHECK;
			pu_ms_ff <= 16'h0000;
			beep_ph_ff <= 3'h0;
			buzzer_ff <= 1'b0;
			param_ff <= 1'b0;
		end else begin
			pu_ff <= nxt_pu;
			// R12 flag tracks the state register
			param_ff <= (nxt_pu == PU_PARAM);
			if (pu_ff != nxt_pu || phase_done)
				pu_ms_ff <= 16'h0000;
			else if (tick_ff)
				pu_ms_ff <= pu_ms_ff + 16'h0001;
			if (phase_done)
				beep_ph_ff <= beep_ph_ff + 3'h1;
			// R14 buzzer on even phases
			buzzer_ff <= (nxt_pu == PU_BEEP) && !beep_ph_ff[0] && !phase_done;
		end
	end

	// parameter registers, writable only in parameter mode
	assign wr_ok = WR && (pu_ff == PU_PARAM);

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			// R17 limits disabled by default
			cfg_ff <= `SOV_CFG_RESET;
			fix_ff[0] <= `SOV_LIM_RESET;
			fix_ff[1] <= `SOV_LIM_RESET;
			max_ff[0] <= `SOV_LIM_RESET;
			max_ff[1] <= `SOV_LIM_RESET;
		end else if (wr_ok) begin
			case (ADDR)
				`SOV_A_CFG: cfg_ff <= WDATA[7:0];
				`SOV_A_FIX1: fix_ff[0] <= WDATA[16:0];
				`SOV_A_FIX2: fix_ff[1] <= WDATA[16:0];
				`SOV_A_MAX1: max_ff[0] <= WDATA[16:0];
				`SOV_A_MAX2: max_ff[1] <= WDATA[16:0];
				default: cfg_ff <= cfg_ff;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N)
			rdata_ff <= 32'h00000000;
		else if (RD) begin
			case (ADDR)
				`SOV_A_CFG: rdata_ff <= {24'h000000, cfg_ff};
				`SOV_A_FIX1: rdata_ff <= {15'h0000, fix_ff[0]};
				`SOV_A_FIX2: rdata_ff <= {15'h0000, fix_ff[1]};
				`SOV_A_MAX1: rdata_ff <= {15'h0000, max_ff[0]};
				`SOV_A_MAX2: rdata_ff <= {15'h0000, max_ff[1]};
				`SOV_A_STAT: rdata_ff <= {12'h000, disp_ff, 1'b0, lvl_ff, 1'b0, pu_ff,
					dmg_ff, ovl_err_ff, ovl_ff, (pu_ff == PU_PARAM)};
				default: rdata_ff <= 32'h00000000;
			endcase
		end else
			rdata_ff <= 32'h00000000;
	end

	// load level and overload timing
	always_comb begin
		if (lvl_ff >= `SOV_LVL6_LEDS)
			lim_ms = LIM6_MS;
		else if (lvl_ff == `SOV_LVL5_LEDS)
			lim_ms = LIM5_MS;
		else
			lim_ms = LIM4_MS;
	end

	// R4 R5 R6 level-dependent limit
	assign timeout = ovl_ff && (ovl_ms_ff >= lim_ms);

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lvl_ff <= 3'h0;
			ovl_ff <= 1'b0;
			ovl_ms_ff <= 16'h0000;
		end else begin
			lvl_ff <= LOAD_LEDS;
			// R1 four or more segments
			ovl_ff <= (LOAD_LEDS >= `SOV_OVL_MIN_LEDS);
			// R23 restart below four
			if (!ovl_ff)
				ovl_ms_ff <= 16'h0000;
			else if (tick_ff && !timeout)
				ovl_ms_ff <= ovl_ms_ff + 16'h0001;
		end
	end

	// error release requests
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rel_prev_ff <= 1'b0;
			rel_arm_ff <= 1'b0;
			btn_prev_ff <= 1'b0;
		end else begin
			rel_prev_ff <= ERR_RELEASE;
			btn_prev_ff <= PANEL_RESET_BTN;
			// R22 off then on arms
			if (!AUTO_MODE || !ERR_RELEASE)
				rel_arm_ff <= 1'b0;
			else if (!rel_prev_ff)
				rel_arm_ff <= 1'b1;
		end
	end

	// R22 final off releases
	assign release_req = (pu_ff == PU_NORMAL) &&
		(AUTO_MODE ? (rel_arm_ff && !ERR_RELEASE) : (PANEL_RESET_BTN && !btn_prev_ff));

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ovl_err_ff <= 1'b0;
			dmg_ff <= 1'b0;
		end else begin
			// R7 timeout sets fault, set wins
			if (timeout)
				ovl_err_ff <= 1'b1;
			else if (release_req)
				ovl_err_ff <= 1'b0;
			// R10 permanent latch
			if (INT_DAMAGE)
				dmg_ff <= 1'b1;
		end
	end

	assign err_any = ovl_err_ff || dmg_ff;

	// warning blink
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			blink_ms_ff <= 16'h0000;
			blink_ff <= 1'b0;
		end else if (!ovl_ff) begin
			blink_ms_ff <= 16'h0000;
			blink_ff <= 1'b1;
		end else if (tick_ff) begin
			if (blink_ms_ff == BLINK_MS - 16'h0001) begin
				blink_ms_ff <= 16'h0000;
				blink_ff <= !blink_ff;
			end else
				blink_ms_ff <= blink_ms_ff + 16'h0001;
		end
	end

	// display code, damage first
	always_comb begin
		if (dmg_ff)
			cur_code = `SOV_CODE_DMG;
		else if (ovl_err_ff)
			cur_code = `SOV_CODE_E8;
		else if (ovl_ff)
			cur_code = `SOV_CODE_A3;
		else
			cur_code = `SOV_CODE_NONE;
	end

	// pattern frame: start one, code msb first, stop zero
	assign pat_frame = {1'b1, cur_code, 1'b0};
	assign pat_bit = pat_frame[4'(`SOV_PAT_LAST_BIT - pat_idx_ff)];

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pat_ms_ff <= 16'h0000;
			pat_idx_ff <= 4'h0;
		end else if (!cfg_ff[`SOV_CFG_PAT] || cur_code == `SOV_CODE_NONE) begin
			pat_ms_ff <= 16'h0000;
			pat_idx_ff <= 4'h0;
		end else if (tick_ff) begin
			if (pat_ms_ff == PAT_MS - 16'h0001) begin
				pat_ms_ff <= 16'h0000;
				pat_idx_ff <= (pat_idx_ff == `SOV_PAT_LAST_BIT) ? 4'h0 : pat_idx_ff + 4'h1;
			end else
				pat_ms_ff <= pat_ms_ff + 16'h0001;
		end
	end

	// indicators and external lines
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			warn_led_ff <= 1'b0;
			err_led_ff <= 1'b0;
			disp_ff <= `SOV_CODE_NONE;
			warn_out_ff <= 1'b0;
			err_out_ff <= 1'b0;
			run_out_ff <= 1'b0;
		end else begin
			// R1 R23 blink while overloaded
			warn_led_ff <= ovl_ff && blink_ff;
			// R7 error indicator
			err_led_ff <= err_any;
			// R2 R8 display code
			disp_ff <= cur_code;
			if (cfg_ff[`SOV_CFG_PAT]) begin
				// R15 patterned code
				err_out_ff <= err_any && pat_bit;
				warn_out_ff <= !err_any && ovl_ff && pat_bit;
			end else begin
				// R8 R9 error line polarity
				err_out_ff <= err_any ^ cfg_ff[`SOV_CFG_ERR_INV];
				// R3 warning line
				warn_out_ff <= ovl_ff;
			end
			// R21 run output polarity
			run_out_ff <= MOTOR_TURNING ^ cfg_ff[`SOV_CFG_RUN_POL];
		end
	end

	// speed selection and limits
	assign sel_fix = fix_ff[MOTOR_SEL];
	assign sel_max = max_ff[MOTOR_SEL];

	always_comb begin
		// R16 R19 speed source
		if (!AUTO_MODE || cfg_ff[`SOV_CFG_PANEL_ADJ])
			src_speed = PANEL_SPEED;
		else begin
			case (sov_src_e'(cfg_ff[`SOV_CFG_SRC_HI:`SOV_CFG_SRC_LO]))
				SRC_ANALOG: src_speed = ANALOG_SPEED;
				SRC_PULSE: src_speed = PULSE_SPEED;
				SRC_POINT: src_speed = POINT_SPEED;
				default: src_speed = ANALOG_SPEED;
			endcase
		end
		// R17 fixed then maximum
		lim_speed = sel_fix[`SOV_LIM_EN] ? sel_fix[15:0] : src_speed;
		if (sel_max[`SOV_LIM_EN] && lim_speed > sel_max[15:0])
			lim_speed = sel_max[15:0];
		// R18 cap without air check
		if (cfg_ff[`SOV_CFG_AIR_OVR] && lim_speed > `SOV_AIR_CAP_RPM)
			lim_speed = `SOV_AIR_CAP_RPM;
	end

	assign start_req = AUTO_MODE ? START_CMD : PANEL_START;

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			motor_en_ff <= 1'b0;
			motor_rev_ff <= 1'b0;
			speed_ff <= 16'h0000;
		end else begin
			// R7 R11 R18 start gating
			motor_en_ff <= (pu_ff == PU_NORMAL) && start_req && !err_any && !timeout &&
				(AIR_OK || cfg_ff[`SOV_CFG_AIR_OVR]);
			// R20 reverse with start
			motor_rev_ff <= (pu_ff == PU_NORMAL) && AUTO_MODE && cfg_ff[`SOV_CFG_DIR_EN] &&
				DIR_IN && START_CMD;
			speed_ff <= lim_speed;
		end
	end

	assign RDATA = rdata_ff;
	assign MOTOR_EN = motor_en_ff;
	assign MOTOR_REV = motor_rev_ff;
	assign SPEED_CMD = speed_ff;
	assign WARN_LED = warn_led_ff;
	assign ERR_LED = err_led_ff;
	assign DISP_CODE = disp_ff;
	assign WARN_OUT = warn_out_ff;
	assign ERR_OUT = err_out_ff;
	assign RUN_OUT = run_out_ff;
	assign BUZZER = buzzer_ff;
	assign PARAM_MODE = param_ff;

	// checks
	property p_warn_code;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(ovl_ff && !err_any) |=> (DISP_CODE == `SOV_CODE_A3);
	endproperty
	a_warn_code: assert property (p_warn_code) else $error("A3 not shown"); // R2

	property p_warn_line;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(ovl_ff && !cfg_ff[`SOV_CFG_PAT]) |=> WARN_OUT;
	endproperty
	a_warn_line: assert property (p_warn_line) else $error("warning line idle"); // R3

	property p_lim4;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(ovl_ff && lvl_ff == `SOV_OVL_MIN_LEDS && ovl_ms_ff >= LIM4_MS) |=> ovl_err_ff;
	endproperty
	a_lim4: assert property (p_lim4) else $error("four level fault late"); // R4

	property p_lim5;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(ovl_ff && lvl_ff == `SOV_LVL5_LEDS && ovl_ms_ff >= LIM5_MS) |=> ovl_err_ff;
	endproperty
	a_lim5: assert property (p_lim5) else $error("five level fault late"); // R5

	property p_lim6;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(ovl_ff && lvl_ff >= `SOV_LVL6_LEDS && ovl_ms_ff >= LIM6_MS) |=> ovl_err_ff;
	endproperty
	a_lim6: assert property (p_lim6) else $error("six level fault late"); // R6

	property p_stop;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		err_any |=> (!MOTOR_EN && ERR_LED);
	endproperty
	a_stop: assert property (p_stop) else $error("motor runs in error"); // R7

	property p_e8;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(ovl_err_ff && !dmg_ff) |=> (DISP_CODE == `SOV_CODE_E8);
	endproperty
	a_e8: assert property (p_e8) else $error("E8 not shown"); // R8

	property p_err_pol;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		!cfg_ff[`SOV_CFG_PAT] |=> (ERR_OUT == ($past(err_any) ^ $past(cfg_ff[0])));
	endproperty
	a_err_pol: assert property (p_err_pol) else $error("error line polarity"); // R9

	property p_dmg_latch;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		dmg_ff |=> dmg_ff [*4];
	endproperty
	a_dmg_latch: assert property (p_dmg_latch) else $error("damage fault cleared"); // R10

	property p_param_stop;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		PARAM_MODE |=> (!MOTOR_EN && PARAM_MODE);
	endproperty
	a_param_stop: assert property (p_param_stop) else $error("param mode leak"); // R11

	property p_air_cap;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		cfg_ff[`SOV_CFG_AIR_OVR] |=> (SPEED_CMD <= `SOV_AIR_CAP_RPM);
	endproperty
	a_air_cap: assert property (p_air_cap) else $error("air cap exceeded"); // R18

	property p_run_pol;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		$changed(MOTOR_TURNING) |=> (RUN_OUT == (MOTOR_TURNING ^ cfg_ff[`SOV_CFG_RUN_POL]));
	endproperty
	a_run_pol: assert property (p_run_pol) else $error("run output wrong"); // R21

	property p_restart;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		!ovl_ff |=> (ovl_ms_ff == 16'h0000 && !WARN_LED);
	endproperty
	a_restart: assert property (p_restart) else $error("overload timer kept"); // R23
endmodule

// ==== testbench/sov_cnc.sv ====
// machine controller model on the external connector of the spindle block
// assumes its tasks are called from one process in the core clock domain
module sov_cnc (
	// clock
	input wire logic core_clk,
	// connector lines towards the spindle controller
	output logic start_cmd,
	output logic dir_in,
	output logic err_release
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		start_cmd = 1'b0;
		dir_in = 1'b0;
		err_release = 1'b0;
	end

	task automatic run(input logic rev);
		@(posedge core_clk);
		dir_in <= rev;
		start_cmd <= 1'b1;
	endtask

	task automatic halt();
		@(posedge core_clk);
		start_cmd <= 1'b0;
		dir_in <= 1'b0;
	endtask

	task automatic release_err(input int on_cyc);
		@(posedge core_clk);
		err_release <= 1'b0;
		repeat (2) @(posedge core_clk);
		err_release <= 1'b1;
		repeat (on_cyc) @(posedge core_clk);
		err_release <= 1'b0;
	endtask
endmodule

// ==== testbench/tb_spindle_overload_and_param_mode.sv ====
// self-checking bench for the spindle overload supervisor
// assumes the machine model sov_cnc and a ms tick of one core cycle
`include "sov_consts.svh"
module tb_spindle_overload_and_param_mode;
	timeunit 1ns;
	timeprecision 1ps;
	import sov_pkg::*;

	logic clk, arst_n, we, re, btn, pstart, auto_m, dmg, air, turning, msel, buz_q;
	logic start_cmd, dir_in, err_rel, men, mrev, wled, eled, wout, eout, rout, buz, pmode;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	sov_lvl_t leds;
	sov_speed_t an_spd, pu_spd, pt_spd, pn_spd, spd;
	sov_code_t disp;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc_n = 0;
	int beeps = 0;
	logic [7:0] cfgs [4] = '{8'h31, 8'h71, 8'hB1, 8'h35};
	sov_speed_t exps [4] = '{16'h0D80, 16'h04D2, 16'h0929, 16'h7530};

	sov_top #(.TICK_CYCLES(1)) sov_top_i (
		.CORE_CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(we), .RD(re),
		.RDATA(rdata), .LOAD_LEDS(leds), .PANEL_RESET_BTN(btn), .PANEL_START(pstart),
		.AUTO_MODE(auto_m), .START_CMD(start_cmd), .DIR_IN(dir_in), .ERR_RELEASE(err_rel),
		.INT_DAMAGE(dmg), .AIR_OK(air), .MOTOR_TURNING(turning), .MOTOR_SEL(msel),
		.ANALOG_SPEED(an_spd), .PULSE_SPEED(pu_spd), .POINT_SPEED(pt_spd),
		.PANEL_SPEED(pn_spd), .MOTOR_EN(men), .MOTOR_REV(mrev), .SPEED_CMD(spd),
		.WARN_LED(wled), .ERR_LED(eled), .DISP_CODE(disp), .WARN_OUT(wout), .ERR_OUT(eout),
		.RUN_OUT(rout), .BUZZER(buz), .PARAM_MODE(pmode)
	);

	sov_cnc sov_cnc_i (
		.core_clk(clk), .start_cmd(start_cmd), .dir_in(dir_in), .err_release(err_rel)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard and buzzer pulse count
	always @(posedge clk) begin
		cyc_n++;
		buz_q <= buz;
		if (buz === 1'b1 && buz_q === 1'b0) beeps++;
		if (cyc_n == 80000) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t timeout", $time);
			final_report();
		end
	end

	task automatic final_report();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		@(posedge clk);
		chk(rdata, exp);
	endtask

	task automatic pwr(input logic b);
		arst_n <= 1'b0;
		btn <= b;
		cyc(8);
		arst_n <= 1'b1;
	endtask

	initial begin
		arst_n = 1'b0;
		{we, re, btn, pstart, auto_m, dmg, turning, msel, buz_q, leds, addr, wdata} = '0;
		air = 1'b1;
		an_spd = 16'h0D80;
		pu_spd = 16'h04D2;
		pt_spd = 16'h0929;
		pn_spd = 16'h9C40;
		pwr(1'b0);
		cyc(3);
		chk(pmode, 0);
		chk(eout, 0);
		for (int a = 0; a < 5; a++) rd(8'(4 * a), 0);
		wr(`SOV_A_CFG, 32'h0000_0001);
		rd(`SOV_A_CFG, 0);
		rd(8'h18, 0);
		pstart <= 1'b1;
		turning <= 1'b1;
		cyc(5);
		chk(men, 1);
		chk(rout, 1);
		turning <= 1'b0;
		cyc(3);
		chk(rout, 0);
		leds <= 3'h6;
		cyc(4);
		chk(wout, 1);
		chk(disp, `SOV_CODE_A3);
		cyc(100);
		chk(wled, 1);
		cyc(250);
		chk(wled, 0);
		cyc(4616);
		chk(eout, 0);
		cyc(60);
		chk(eout, 1);
		chk(eled, 1);
		chk(men, 0);
		chk(disp, `SOV_CODE_E8);
		leds <= 3'h0;
		cyc(4);
		chk(wout, 0);
		btn <= 1'b1;
		cyc(2);
		btn <= 1'b0;
		cyc(4);
		chk(eout, 0);
		leds <= 3'h5;
		cyc(6000);
		leds <= 3'h3;
		cyc(3);
		leds <= 3'h5;
		cyc(9960);
		chk(eout, 0);
		cyc(60);
		chk(eout, 1);
		leds <= 3'h0;
		auto_m <= 1'b1;
		sov_cnc_i.release_err(3);
		cyc(4);
		chk(eout, 0);
		sov_cnc_i.run(1'b1);
		cyc(4);
		chk(men, 1);
		chk(mrev, 0);
		sov_cnc_i.halt();
		leds <= 3'h4;
		cyc(29960);
		chk(eout, 0);
		cyc(60);
		chk(eout, 1);
		leds <= 3'h0;
		sov_cnc_i.release_err(3);
		cyc(4);
		chk(eout, 0);
		dmg <= 1'b1;
		cyc(2);
		dmg <= 1'b0;
		cyc(4);
		chk(disp, `SOV_CODE_DMG);
		sov_cnc_i.release_err(3);
		auto_m <= 1'b0;
		btn <= 1'b1;
		cyc(2);
		btn <= 1'b0;
		cyc(4);
		chk(eout, 1);
		pwr(1'b1);
		cyc(3700);
		chk(beeps, 3);
		chk(pmode, 0);
		btn <= 1'b0;
		cyc(4);
		chk(pmode, 1);
		chk(men, 0);
		wr(`SOV_A_CFG, 32'h0000_0031);
		rd(`SOV_A_CFG, 32'h0000_0031);
		chk(eout, 1);
		chk(rout, 1);
		wr(`SOV_A_MAX1, 32'h0001_4E20);
		cyc(3);
		chk(spd, 16'h4E20);
		msel <= 1'b1;
		cyc(3);
		chk(spd, `SOV_AIR_CAP_RPM);
		auto_m <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(`SOV_A_CFG, {24'h0, cfgs[i]});
			cyc(3);
			chk(spd, exps[i]);
		end
		wr(`SOV_A_FIX2, 32'h0001_0BB8);
		cyc(3);
		chk(spd, 16'h0BB8);
		wr(`SOV_A_CFG, 32'h0000_0002);
		leds <= 3'h4;
		cyc(5);
		chk(wout, 1);
		cyc(20);
		chk(wout, 0);
		leds <= 3'h0;
		auto_m <= 1'b0;
		pwr(1'b0);
		cyc(4);
		chk(pmode, 0);
		chk(men, 1);
		pwr(1'b1);
		cyc(1000);
		btn <= 1'b0;
		cyc(3000);
		chk(pmode, 0);
		chk(beeps, 3);
		final_report();
	end
endmodule
